// [inc/mcabt_params.svh]
// Purpose: Constants for the microcore ALU, bias and threshold decoder
// Assumes: 16-bit instruction and register words
// Notes: Grant register indices; byte address is four times the index
`ifndef MCABT_PARAMS_SVH
`define MCABT_PARAMS_SVH
// ==========================================================
// Register map
`define MCABT_GRANT_A_IDX 12'h184
`define MCABT_GRANT_B_IDX 12'h185
`define MCABT_GRANT_C_IDX 12'h186
`define MCABT_GRANT_D_IDX 12'h187
`define MCABT_CTRL_IDX 12'h188
`define MCABT_STATUS_IDX 12'h189
`define MCABT_BIAS_IDX 12'h18a
`define MCABT_GRANT_RST 16'h0000
// ==========================================================
// Opcodes
`define MCABT_OP_ADDI 6'h06
`define MCABT_OP_AND 13'h05d9
`define MCABT_OP_BIAS 11'h1b1
`define MCABT_OP_CHTH 9'h05f
`define MCABT_OP_COPY 3'h5
// ==========================================================
// Register codes and mask constants
`define MCABT_ALU_IMM 3'h5
`define MCABT_ALU_MH 3'h6
`define MCABT_ALU_ML 3'h7
`define MCABT_MASK_ONES 16'hffff
`define MCABT_MASK_ZERO 16'h0000
`endif

// [inc/mcabt_pkg.sv]
// Purpose: Types for the microcore ALU, bias and threshold decoder
// Assumes: Included constants header
// Notes: Flags travel as one packed struct
package mcabt_pkg;
  typedef struct packed {
    logic carry;
    logic result_zero_flag;
    logic result_negative_flag;
    logic unsigned_underflow_flag;
    logic unsigned_overflow_flag;
    logic signed_underflow_flag;
    logic signed_overflow_flag;
    logic mask_all_zero_flag;
    logic mask_all_ones_flag;
  } mcabt_flags_t;
  typedef enum logic [2:0] {
    MCABT_IDLE = 3'b001,
    MCABT_EXEC = 3'b010,
    MCABT_DONE = 3'b100
  } mcabt_state_t;
endpackage : mcabt_pkg

// [hw/mcabt_core.sv]
// Purpose: Decode and execute addi, and-mask, bias, threshold change, copy
// Assumes: One instruction per strobe, every instruction done in one cycle
// Notes: Grant bit n of the grant registers covers output n (hs1..hs5, ls1..ls6)
// Contract
// - Add-immediate adds a 4-bit immediate to a source ALU register.
// - Add-immediate updates carry, zero, negative, unsigned and signed limit flags.
// - Mask ANDs a register with the immediate register, result back in place.
// - Mask all-zero flag set when masked result is zero.
// - Mask all-ones flag set when masked result is all ones.
// - Bias control bit one enables, zero disables the selected structure.
// - Bias takes effect only with drive right from the grant registers.
// - Bias codes 0-4 high-side, 5-9 low-side, 12 ls6, 10-11 strong.
// - Bias code 13 all, 14 all high-side with strong, 15 all low-side.
// - Threshold change sets a new level on the selected comparator.
// - Threshold unchanged unless the drive right for the output is held.
// - High-side source thresholds also depend on bootstrap initialization mode.
// - Comparator codes 0-9 alternate vds/src for hs1-5, 10-15 ls1-6 vds.
// - Three-bit level selects one of eight ascending levels.
// - Copy moves any full-set register to any full-set register.
// - Load, store and copy complete in one core clock cycle.
// - ALU code 0-4 general, 5 immediate, 6 multiplier high, 7 low.
// - Full code 0-7 ALU registers, higher codes the other core registers.
`timescale 1ns/1ps
`include "mcabt_params.svh"
module mcabt_core (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic instr_valid,
  input wire logic [15:0] instr_word,
  input wire logic bootstrap_mode,
  input wire logic [11:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  output logic instr_done,
  output logic instr_illegal,
  output mcabt_pkg::mcabt_flags_t flags,
  output logic [12:0] bias_enable,
  output logic [47:0] hs_vds_threshold,
  output logic [14:0] hs_src_threshold,
  output logic [17:0] ls_vds_threshold
);
  import mcabt_pkg::*;

  // ==========================================================
  // Storage
  logic [15:0] full_register_set_r [32];
  logic [15:0] grant_r [4];
  logic [15:0] ctrl_r;
  mcabt_flags_t flags_r, flags_nxt;
  logic [12:0] bias_r, bias_nxt;
  logic [2:0] thr_r [16];
  logic [15:0] rdata_r;
  logic done_r, illegal_r;
  mcabt_state_t state_r;

  function automatic logic [15:0] alu_read(input logic [2:0] code,
                                           input logic [15:0] v0, input logic [15:0] v1,
                                           input logic [15:0] v2, input logic [15:0] v3,
                                           input logic [15:0] v4, input logic [15:0] v5,
                                           input logic [15:0] v6, input logic [15:0] v7);
    logic [15:0] r;
    unique case (code)
      3'h0: r = v0;
      3'h1: r = v1;
      3'h2: r = v2;
      3'h3: r = v3;
      3'h4: r = v4;
      3'h5: r = v5;
      3'h6: r = v6;
      3'h7: r = v7;
    endcase
    return r;
  endfunction : alu_read

  // ==========================================================
  // Decode
  wire [15:0] grant_all = grant_r[0] | grant_r[1] | grant_r[2] | grant_r[3];
  wire is_addi = instr_valid && instr_word[15:10] == `MCABT_OP_ADDI;
  wire is_and = instr_valid && instr_word[15:3] == `MCABT_OP_AND;
  wire is_bias = instr_valid && instr_word[15:5] == `MCABT_OP_BIAS;
  wire is_chth = instr_valid && instr_word[15:7] == `MCABT_OP_CHTH;
  wire is_copy = instr_valid && instr_word[15:13] == `MCABT_OP_COPY
                 && instr_word[2:0] == 3'h0;
  wire is_any = is_addi | is_and | is_bias | is_chth | is_copy;
  wire [2:0] addi_dst = instr_word[9:7];
  wire [3:0] addi_imm = instr_word[6:3];
  wire [2:0] alu_src = instr_word[2:0];
  wire [15:0] src_val = alu_read(alu_src, full_register_set_r[0], full_register_set_r[1],
                                 full_register_set_r[2], full_register_set_r[3],
                                 full_register_set_r[4], full_register_set_r[5],
                                 full_register_set_r[6], full_register_set_r[7]);
  wire [15:0] imm_reg = full_register_set_r[`MCABT_ALU_IMM];
  wire [16:0] sum = {1'b0, src_val} + {13'h0000, addi_imm};
  wire [15:0] masked = src_val & imm_reg;
  wire signed_ovf = !src_val[15] && sum[15];
  wire [4:0] copy_src = instr_word[12:8];
  wire [4:0] copy_dst = instr_word[7:3];
  wire [15:0] copy_val = full_register_set_r[copy_src];

  // Bias target decode, one bit per structure: hs1..5, ls1..6, highside2_strong_bias, highside4_strong_bias
  wire bias_ctrl = instr_word[4];
  wire [3:0] bias_target_select = instr_word[3:0];
  logic [12:0] bias_sel;
  always_comb begin
    bias_sel = 13'h0000;
    unique case (bias_target_select)
      4'hc: bias_sel = 13'h0400;
      4'ha: bias_sel = 13'h0800;
      4'hb: bias_sel = 13'h1000;
      4'hd: bias_sel = 13'h1fff;
      4'he: bias_sel = 13'h181f;
      4'hf: bias_sel = 13'h07e0;
      default: bias_sel = 13'h0001 << bias_target_select;
    endcase
  end
  // Strong structures follow the right of their own high-side output
  wire [12:0] bias_right = {grant_all[3], grant_all[1], grant_all[10:0]};
  wire [12:0] bias_apply = bias_sel & bias_right;
  always_comb begin
    bias_nxt = bias_r;
    if (is_bias) begin
      bias_nxt = (bias_r & ~bias_apply) | (bias_apply & {13{bias_ctrl}});
    end
  end

  // Comparator decode: output owning the comparator
  wire [3:0] comparator_select = instr_word[6:3];
  wire [2:0] threshold_level_select = instr_word[2:0];
  wire [3:0] cmp_output = comparator_select < 4'ha ? {1'b0, comparator_select[3:1]}
                          : comparator_select - 4'h5;
  wire cmp_right = grant_all[cmp_output];

  // ==========================================================
  // Flags
  always_comb begin
    flags_nxt = flags_r;
    if (is_addi) begin
      flags_nxt.carry = sum[16];
      flags_nxt.result_zero_flag = sum[15:0] == 16'h0000;
      flags_nxt.result_negative_flag = sum[15];
      flags_nxt.unsigned_underflow_flag = 1'b0;
      flags_nxt.unsigned_overflow_flag = sum[16];
      flags_nxt.signed_underflow_flag = 1'b0;
      flags_nxt.signed_overflow_flag = signed_ovf;
    end else if (is_and) begin
      flags_nxt.mask_all_zero_flag = masked == `MCABT_MASK_ZERO;
      flags_nxt.mask_all_ones_flag = masked == `MCABT_MASK_ONES;
    end
  end

  // ==========================================================
  // Register bus decode
  wire grant_hit = reg_addr[11:2] == 10'h061;
  wire [1:0] grant_idx = reg_addr[1:0];
  logic [15:0] rd_mux;
  always_comb begin
    rd_mux = 16'h0000;
    if (grant_hit) begin
      rd_mux = grant_r[grant_idx];
    end else if (reg_addr == `MCABT_CTRL_IDX) begin
      rd_mux = ctrl_r;
    end else if (reg_addr == `MCABT_STATUS_IDX) begin
      rd_mux = {7'h00, flags_r};
    end else if (reg_addr == `MCABT_BIAS_IDX) begin
      rd_mux = {3'h0, bias_r};
    end
  end

  // ==========================================================
  // Sequential state
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < 32; i++) full_register_set_r[i] <= 16'h0000;
    end else if (is_addi) begin
      full_register_set_r[addi_dst] <= sum[15:0];
    end else if (is_and) begin
      full_register_set_r[alu_src] <= masked;
    end else if (is_copy) begin
      full_register_set_r[copy_dst] <= copy_val;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < 4; i++) grant_r[i] <= `MCABT_GRANT_RST;
      ctrl_r <= 16'h0000;
    end else if (reg_wr) begin
      if (grant_hit) grant_r[grant_idx] <= reg_wdata;
      if (reg_addr == `MCABT_CTRL_IDX) ctrl_r <= reg_wdata;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < 16; i++) thr_r[i] <= 3'h0;
    end else if (is_chth && cmp_right) begin
      thr_r[comparator_select] <= threshold_level_select;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      flags_r <= '0;
      bias_r <= 13'h0000;
      rdata_r <= 16'h0000;
      done_r <= 1'b0;
      illegal_r <= 1'b0;
      state_r <= MCABT_IDLE;
    end else begin
      flags_r <= flags_nxt;
      bias_r <= bias_nxt;
      rdata_r <= reg_rd ? rd_mux : 16'h0000;
      done_r <= is_any;
      illegal_r <= instr_valid && !is_any;
      state_r <= is_any ? MCABT_DONE : MCABT_IDLE;
    end
  end

  // ==========================================================
  // Outputs, bootstrap forces the high-side source thresholds to level zero
  logic [14:0] hs_src_r;
  logic [47:0] hs_vds_r;
  logic [17:0] ls_vds_r;
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      hs_src_r <= 15'h0000;
      hs_vds_r <= 48'h0;
      ls_vds_r <= 18'h00000;
    end else begin
      for (int i = 0; i < 5; i++) begin
        hs_vds_r[i*3 +: 3] <= thr_r[2*i];
        hs_src_r[i*3 +: 3] <= bootstrap_mode ? 3'h0 : thr_r[2*i+1];
      end
      hs_vds_r[47:15] <= 33'h0;
      for (int j = 0; j < 6; j++) ls_vds_r[j*3 +: 3] <= thr_r[10+j];
    end
  end

  assign reg_rdata = rdata_r;
  assign instr_done = done_r;
  assign instr_illegal = illegal_r;
  assign flags = flags_r;
  assign bias_enable = bias_r;
  assign hs_vds_threshold = hs_vds_r;
  assign hs_src_threshold = hs_src_r;
  assign ls_vds_threshold = ls_vds_r;
endmodule : mcabt_core

// [verif/mcabt_core_assertions.sv]
// Purpose: Port-level checks for the decoder core
// Assumes: Outputs answer one cycle after the strobe, thresholds two
// Notes: Bound to every mcabt_core instance
`timescale 1ns/1ps
`include "mcabt_params.svh"
// ==========================================================
// Checker
module mcabt_chk (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic instr_valid,
  input wire logic [15:0] instr_word,
  input wire logic bootstrap_mode,
  input wire logic instr_done,
  input wire logic instr_illegal,
  input wire mcabt_pkg::mcabt_flags_t flags,
  input wire logic [12:0] bias_enable,
  input wire logic [47:0] hs_vds_threshold,
  input wire logic [14:0] hs_src_threshold,
  input wire logic [17:0] ls_vds_threshold
);
  import mcabt_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  wire is_addi = instr_valid && instr_word[15:10] == `MCABT_OP_ADDI;
  wire is_and = instr_valid && instr_word[15:3] == `MCABT_OP_AND;
  wire is_bias = instr_valid && instr_word[15:5] == `MCABT_OP_BIAS;
  wire is_chth = instr_valid && instr_word[15:7] == `MCABT_OP_CHTH;
  wire is_copy = instr_valid && instr_word[15:13] == `MCABT_OP_COPY && instr_word[2:0] == 3'h0;
  chk_addi_done: assert property (is_addi |=> instr_done && !instr_illegal)
    else $error("addi not completed");
  chk_copy_single: assert property (is_copy |=> instr_done)
    else $error("copy not done in one cycle");
  chk_carry_uo: assert property (is_addi |=> flags.unsigned_overflow_flag == flags.carry)
    else $error("overflow flag differs from carry");
  chk_addi_under: assert property (is_addi |=> !flags.unsigned_underflow_flag
    && !flags.signed_underflow_flag)
    else $error("underflow on positive add");
  chk_zero_neg: assert property (is_addi |=> !(flags.result_zero_flag
    && flags.result_negative_flag))
    else $error("zero and negative together");
  chk_mask_excl: assert property (is_and |=> !(flags.mask_all_zero_flag
    && flags.mask_all_ones_flag))
    else $error("both mask flags set");
  chk_bias_off: assert property (is_bias && !instr_word[4]
    |=> (bias_enable & ~$past(bias_enable)) == 13'h0000)
    else $error("disable command set a bias");
  chk_bias_on: assert property (is_bias && instr_word[4]
    |=> (~bias_enable & $past(bias_enable)) == 13'h0000)
    else $error("enable command cleared a bias");
  chk_bias_cause: assert property ($changed(bias_enable) |-> $past(is_bias))
    else $error("bias changed without command");
  chk_ls_cause: assert property ($changed(ls_vds_threshold) |-> $past(is_chth, 2))
    else $error("low-side threshold changed without command");
  chk_hs_untouched: assert property (is_chth && instr_word[6:3] >= 4'ha
    |=> ##1 $stable(hs_vds_threshold))
    else $error("low-side select touched high-side");
  chk_boot_src: assert property (bootstrap_mode [*3] |-> hs_src_threshold == 15'h0000)
    else $error("source threshold not forced in bootstrap");
endmodule : mcabt_chk
bind mcabt_core mcabt_chk chk_u (.clk_sys(clk_sys), .sys_rst(sys_rst),
  .instr_valid(instr_valid), .instr_word(instr_word), .bootstrap_mode(bootstrap_mode),
  .instr_done(instr_done), .instr_illegal(instr_illegal), .flags(flags),
  .bias_enable(bias_enable), .hs_vds_threshold(hs_vds_threshold),
  .hs_src_threshold(hs_src_threshold), .ls_vds_threshold(ls_vds_threshold));

// [verif/mcabt_ucode_model.sv]
// Purpose: Code RAM side issuing one instruction word per request
// Assumes: Request sampled at the rising edge
// Notes: Idle word inverts each cycle so no stale opcode lingers
`timescale 1ns/1ps
module mcabt_ucode (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic issue,
  input wire logic [15:0] word_in,
  output logic instr_valid,
  output logic [15:0] instr_word
);
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      instr_valid <= 1'b0;
      instr_word <= 16'h0000;
    end else begin
      instr_valid <= issue;
      instr_word <= issue ? word_in : ~instr_word;
    end
  end
endmodule : mcabt_ucode

// [verif/microcore_alu_bias_threshold_ops_tb.sv]
// Purpose: Self-checking bench for the decoder core
// Assumes: ALU registers clear at reset
// Notes: Grant B feeds bias cases, grant D threshold cases
`timescale 1ns/1ps
`include "mcabt_params.svh"
module microcore_alu_bias_threshold_ops_tb;
  import mcabt_pkg::*;
  logic clk_sys = 0, sys_rst = 1, issue = 0, bootstrap_mode = 0, reg_wr = 0, reg_rd = 0;
  logic [15:0] word_in = 16'h0000, reg_wdata = 16'h0000, instr_word, reg_rdata;
  logic [15:0] areg [8] = '{default: 16'h0000};
  logic [11:0] reg_addr = 12'h000;
  logic instr_valid, instr_done, instr_illegal;
  mcabt_flags_t flags;
  logic [12:0] bias_enable;
  logic [47:0] hs_vds_threshold;
  logic [14:0] hs_src_threshold;
  logic [17:0] ls_vds_threshold;
  logic [80:0] snap;
  logic [12:0] bias_row [16] = '{13'h0001, 13'h0002, 13'h0004, 13'h0008, 13'h0010, 13'h0020,
    13'h0040, 13'h0080, 13'h0100, 13'h0200, 13'h0800, 13'h1000, 13'h0400, 13'h1fff,
    13'h181f, 13'h07e0};
  int fail_count = 0, total_checks = 0;
  initial forever #5 clk_sys = ~clk_sys;
  mcabt_ucode ucode_u (.clk_sys(clk_sys), .sys_rst(sys_rst), .issue(issue),
    .word_in(word_in), .instr_valid(instr_valid), .instr_word(instr_word));
  mcabt_core dut_u (.clk_sys(clk_sys), .sys_rst(sys_rst), .instr_valid(instr_valid),
    .instr_word(instr_word), .bootstrap_mode(bootstrap_mode), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .instr_done(instr_done), .instr_illegal(instr_illegal), .flags(flags),
    .bias_enable(bias_enable), .hs_vds_threshold(hs_vds_threshold),
    .hs_src_threshold(hs_src_threshold), .ls_vds_threshold(ls_vds_threshold));
  // ==========================================================
  // Tasks
  task automatic chk(string nm, logic [47:0] seen, logic [47:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : close_out
  task automatic wr(logic [11:0] a, logic [15:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(logic [11:0] a, logic [15:0] e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk("rdata", reg_rdata, e);
  endtask : rd
  task automatic ex(logic [15:0] w, logic ok);
    @(posedge clk_sys);
    word_in <= w;
    issue <= 1'b1;
    @(posedge clk_sys);
    issue <= 1'b0;
    @(posedge clk_sys);
    #1 chk("done", {instr_done, instr_illegal}, ok ? 2'h2 : 2'h1);
  endtask : ex
  task automatic addi(int d, int i, int s);
    logic [15:0] a;
    logic [16:0] sum;
    a = areg[s];
    sum = {1'b0, a} + 17'(i);
    ex({`MCABT_OP_ADDI, 3'(d), 4'(i), 3'(s)}, 1'b1);
    areg[d] = sum[15:0];
    chk("addi", flags[8:2], {sum[16], sum[15:0] == 16'h0000, sum[15], 1'b0, sum[16], 1'b0,
      ~a[15] & sum[15]});
  endtask : addi
  task automatic mask(int r);
    areg[r] = areg[r] & areg[5];
    ex({`MCABT_OP_AND, 3'(r)}, 1'b1);
    chk("mask", flags[1:0], {areg[r] == 16'h0000, areg[r] == 16'hffff});
  endtask : mask
  function automatic logic [2:0] fld(int s);
    if (s >= 10) return ls_vds_threshold[3*(s-10)+:3];
    return s[0] ? hs_src_threshold[3*(s/2)+:3] : hs_vds_threshold[3*(s/2)+:3];
  endfunction : fld
  // ==========================================================
  // Sequence
  initial begin
    repeat (6) @(posedge clk_sys);
    sys_rst <= 1'b0;
    #1 chk("rst", {instr_done, flags, bias_enable, hs_src_threshold}, 48'h0);
    chk("rst_thr", hs_vds_threshold | 48'(ls_vds_threshold), 48'h0);
    for (int i = 0; i < 4; i++) rd(`MCABT_GRANT_A_IDX + 12'(i), `MCABT_GRANT_RST);
    rd(12'h1ff, 16'h0000);
    wr(`MCABT_GRANT_B_IDX, 16'h07ff);
    rd(`MCABT_GRANT_B_IDX, 16'h07ff);
    for (int c = 0; c < 16; c++) begin
      ex({`MCABT_OP_BIAS, 1'b1, 4'(c)}, 1'b1);
      chk("bias_on", bias_enable, bias_row[c]);
      ex({`MCABT_OP_BIAS, 1'b0, 4'hd}, 1'b1);
      chk("bias_off", bias_enable, 13'h0000);
    end
    wr(`MCABT_GRANT_B_IDX, 16'h0000);
    ex({`MCABT_OP_BIAS, 1'b1, 4'hd}, 1'b1);
    chk("bias_nogrant", bias_enable, 13'h0000);
    rd(`MCABT_BIAS_IDX, 16'h0000);
    wr(`MCABT_CTRL_IDX, 16'h5a5a);
    rd(`MCABT_CTRL_IDX, 16'h5a5a);
    $display("bias tests done");
    wr(`MCABT_GRANT_D_IDX, 16'h07ff);
    for (int s = 0; s < 16; s++) begin
      ex({`MCABT_OP_CHTH, 4'(s), 3'(s) ^ 3'h3}, 1'b1);
      @(posedge clk_sys);
      #1 chk("thr", fld(s), 3'(s) ^ 3'h3);
    end
    wr(`MCABT_GRANT_D_IDX, 16'h0000);
    snap = {hs_vds_threshold, hs_src_threshold, ls_vds_threshold};
    ex({`MCABT_OP_CHTH, 4'h0, 3'h7}, 1'b1);
    ex({`MCABT_OP_CHTH, 4'hf, 3'h0}, 1'b1);
    @(posedge clk_sys);
    #1 chk("thr_hold", snap === {hs_vds_threshold, hs_src_threshold, ls_vds_threshold}, 1);
    @(posedge clk_sys);
    bootstrap_mode <= 1'b1;
    repeat (3) @(posedge clk_sys);
    #1 chk("boot", hs_src_threshold, 15'h0000);
    @(posedge clk_sys);
    bootstrap_mode <= 1'b0;
    $display("threshold tests done");
    addi(0, 0, 0);
    repeat (4369) addi(1, 15, 1);
    addi(2, 1, 1);
    rd(`MCABT_STATUS_IDX, 16'h0190);
    ex({`MCABT_OP_COPY, 5'h01, 5'h05, 3'h0}, 1'b1);
    areg[5] = areg[1];
    mask(1);
    mask(2);
    addi(5, 3, 2);
    mask(1);
    addi(1, 0, 1);
    ex(16'hffff, 1'b0);
    $display("alu tests done");
    close_out();
  end
  initial begin
    repeat (100000) @(posedge clk_sys);
    fail_count++;
    close_out();
  end
endmodule : microcore_alu_bias_threshold_ops_tb
